// ===== logic/scc_config_regs.sv
`include "scc_map.svh"
// Behaviour
// - Bit 6 selects AC or DC coupling
// - Bit 0 powers down reference receiver
// - Five-bit swing code, resets zero
// - Codes 10 to 19 invert output clock
// - Bit 0 powers down clock driver
module scc_config_regs (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [`SCC_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  output scc_pkg::scc_ref_t ref_cfg,
  output scc_pkg::scc_seq_t seq_cfg,
  output scc_pkg::scc_clk_t clk_cfg
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic coupling_q;
  logic coupling_d;
  logic ref_pd_q;
  logic ref_pd_d;
  logic [2:0] seq_a_q;
  logic [2:0] seq_a_d;
  logic seq_b_q;
  logic seq_b_d;
  logic seq_c_q;
  logic seq_c_d;
  logic [4:0] swing_q;
  logic [4:0] swing_d;
  logic drv_off_q;
  logic drv_off_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic wr_ref;
  logic wr_seq;
  logic wr_swing;
  logic wr_drv;
  logic inv_q;
  logic inv_d;
  logic valid_q;
  logic valid_d;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  always_comb
  begin
    wr_ref = 1'b0;
    wr_seq = 1'b0;
    wr_swing = 1'b0;
    wr_drv = 1'b0;
    if (wr_stb)
    begin
      // Unmapped offsets hit nothing, so the write is dropped
      case (addr)
        `SCC_OFF_SYNC_REF:
          wr_ref = 1'b1;
        `SCC_OFF_NV_SEQ:
          wr_seq = 1'b1;
        `SCC_OFF_SWING:
          wr_swing = 1'b1;
        `SCC_OFF_DRIVER:
          wr_drv = 1'b1;
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Reference receiver
  // ----------------------------------------
  always_comb
  begin
    coupling_d = coupling_q;
    ref_pd_d = ref_pd_q;
    if (wr_ref)
    begin
      // Bits 7 and 5:1 are not stored
      coupling_d = wdata[`SCC_COUPLING_BIT];
      ref_pd_d = wdata[`SCC_REF_PD_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      coupling_q <= `SCC_RST_COUPLING;
      ref_pd_q <= `SCC_RST_REF_PD;
    end
    else
    begin
      coupling_q <= coupling_d;
      ref_pd_q <= ref_pd_d;
    end
  end

  // ----------------------------------------
  // Sequence control
  // ----------------------------------------
  always_comb
  begin
    seq_a_d = seq_a_q;
    seq_b_d = seq_b_q;
    seq_c_d = seq_c_q;
    if (wr_seq)
    begin
      // Plain storage; sequencing is the host's job
      seq_a_d = wdata[`SCC_SEQ_A_HI:`SCC_SEQ_A_LO];
      seq_b_d = wdata[`SCC_SEQ_B_BIT];
      seq_c_d = wdata[`SCC_SEQ_C_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      seq_a_q <= `SCC_RST_SEQ_A;
      seq_b_q <= `SCC_RST_SEQ_B;
      seq_c_q <= `SCC_RST_SEQ_C;
    end
    else
    begin
      seq_a_q <= seq_a_d;
      seq_b_q <= seq_b_d;
      seq_c_q <= seq_c_d;
    end
  end

  // ----------------------------------------
  // Clock output
  // ----------------------------------------
  always_comb
  begin
    swing_d = swing_q;
    drv_off_d = drv_off_q;
    if (wr_swing)
    begin
      swing_d = wdata[`SCC_SWING_HI:`SCC_SWING_LO];
    end
    if (wr_drv)
    begin
      drv_off_d = wdata[`SCC_DRV_OFF_BIT];
    end
  end

  // Decoded from the next code so the flags move with it
  scc_swing_decode u_decode (
    .code(swing_d),
    .inverted(inv_d),
    .valid(valid_d)
  );

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      swing_q <= `SCC_RST_SWING;
      drv_off_q <= `SCC_RST_DRIVER;
      inv_q <= `SCC_RST_INVERTED;
      valid_q <= `SCC_RST_VALID;
    end
    else
    begin
      swing_q <= swing_d;
      drv_off_q <= drv_off_d;
      inv_q <= inv_d;
      valid_q <= valid_d;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb
  begin
    rdata_d = 8'h00;
    if (rd_stb)
    begin
      // Unmapped addresses and reserved bits read zero
      case (addr)
        `SCC_OFF_SYNC_REF:
        begin
          rdata_d[`SCC_COUPLING_BIT] = coupling_q;
          rdata_d[`SCC_REF_PD_BIT] = ref_pd_q;
        end
        `SCC_OFF_NV_SEQ:
        begin
          rdata_d[`SCC_SEQ_A_HI:`SCC_SEQ_A_LO] = seq_a_q;
          rdata_d[`SCC_SEQ_B_BIT] = seq_b_q;
          rdata_d[`SCC_SEQ_C_BIT] = seq_c_q;
        end
        `SCC_OFF_SWING:
          rdata_d[`SCC_SWING_HI:`SCC_SWING_LO] = swing_q;
        `SCC_OFF_DRIVER:
          rdata_d[`SCC_DRV_OFF_BIT] = drv_off_q;
        default:
          rdata_d = 8'h00;
      endcase
    end
  end

  // Read data stands one cycle, then returns to zero
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rdata_q <= `SCC_RST_RDATA;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata = rdata_q;
  assign ref_cfg.ref_input_coupling_select = coupling_q;
  assign ref_cfg.ref_receiver_powerdown = ref_pd_q;
  assign seq_cfg.nonvolatile_seq_field_a = seq_a_q;
  assign seq_cfg.nonvolatile_seq_field_b = seq_b_q;
  assign seq_cfg.nonvolatile_seq_field_c = seq_c_q;
  assign clk_cfg.aux_clock_swing_code = swing_q;
  assign clk_cfg.swing_inverted = inv_q;
  assign clk_cfg.swing_valid = valid_q;
  assign clk_cfg.aux_clock_driver_off = drv_off_q;
endmodule

// ===== logic/scc_swing_decode.sv
`include "scc_map.svh"
// ----------------------------------------
// Swing range decode
// ----------------------------------------
module scc_swing_decode (
  input wire logic [4:0] code,
  output logic inverted,
  output logic valid
);
  always_comb
  begin
    // Second range drives an inverted clock
    inverted = (code >= `SCC_SWING_NEG_MIN) &&
               (code <= `SCC_SWING_NEG_MAX);
    // Codes above 19 have no defined swing
    valid = (code <= `SCC_SWING_POS_MAX) || inverted;
  end
endmodule

// ===== shared/scc_map.svh
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCC_ADDR_W 12
`define SCC_OFF_SYNC_REF 12'h084
`define SCC_OFF_NV_SEQ 12'h085
`define SCC_OFF_SWING 12'h08d
`define SCC_OFF_DRIVER 12'h08f
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCC_COUPLING_BIT 6
`define SCC_REF_PD_BIT 0
`define SCC_SEQ_A_HI 6
`define SCC_SEQ_A_LO 4
`define SCC_SEQ_B_BIT 1
`define SCC_SEQ_C_BIT 0
`define SCC_SWING_HI 4
`define SCC_SWING_LO 0
`define SCC_DRV_OFF_BIT 0
// ----------------------------------------
// Reset values and swing ranges
// ----------------------------------------
`define SCC_RST_COUPLING 1'h0
`define SCC_RST_REF_PD 1'h0
`define SCC_RST_RDATA 8'h00
`define SCC_RST_INVERTED 1'h0
`define SCC_RST_VALID 1'h1
`define SCC_RST_SEQ_A 3'h1
`define SCC_RST_SEQ_B 1'h1
`define SCC_RST_SEQ_C 1'h1
`define SCC_RST_SWING 5'h00
`define SCC_RST_DRIVER 1'h0
`define SCC_SWING_POS_MAX 5'h09
`define SCC_SWING_NEG_MIN 5'h0a
`define SCC_SWING_NEG_MAX 5'h13
`endif

// ===== shared/scc_pkg.sv
package scc_pkg;
  typedef struct packed {
    logic ref_input_coupling_select;
    logic ref_receiver_powerdown;
  } scc_ref_t;

  typedef struct packed {
    logic [2:0] nonvolatile_seq_field_a;
    logic nonvolatile_seq_field_b;
    logic nonvolatile_seq_field_c;
  } scc_seq_t;

  typedef struct packed {
    logic [4:0] aux_clock_swing_code;
    logic swing_inverted;
    logic swing_valid;
    logic aux_clock_driver_off;
  } scc_clk_t;
endpackage

// ===== verif/scc_config_regs_tb.sv
module scc_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] addr;
  logic [7:0] wdata, rdata, d;
  logic wr_stb, rd_stb;
  scc_pkg::scc_ref_t ref_cfg;
  scc_pkg::scc_seq_t seq_cfg;
  scc_pkg::scc_clk_t clk_cfg;
  int bad_count = 0;
  int total_checks = 0;
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end
  scc_host i_host (.ref_clk(ref_clk), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb));
  scc_config_regs i_dut (.ref_clk(ref_clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .ref_cfg(ref_cfg), .seq_cfg(seq_cfg), .clk_cfg(clk_cfg));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
    i_host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    rchk(12'h084, 8'h00);
    rchk(12'h085, 8'h13);
    rchk(12'h08d, 8'h00);
    rchk(12'h08f, 8'h00);
    $display("reset values done");
    i_host.wr(12'h084, 8'hff);
    rchk(12'h084, 8'h41);
    chk(8'(ref_cfg), 8'h03);
    i_host.wr(12'h085, 8'hff);
    rchk(12'h085, 8'h73);
    i_host.wr(12'h085, 8'h12);
    i_host.wr(12'h084, 8'h01);
    rchk(12'h084, 8'h01);
    chk(8'(seq_cfg), 8'h06);
    i_host.wr(12'h085, 8'h01);
    rchk(12'h085, 8'h01);
    $display("sequence done");
    for (int c = 0; c < 32; c++)
    begin
      i_host.wr(12'h08d, 8'he0 | 8'(c));
      rchk(12'h08d, 8'(c));
      chk(8'(clk_cfg[2]), 8'(c >= 10 && c <= 19));
      chk(8'(clk_cfg[7:3]), 8'(c));
      chk(8'(clk_cfg[1]), 8'(c <= 19));
    end
    $display("swing done");
    i_host.wr(12'h08f, 8'hff);
    rchk(12'h08f, 8'h01);
    chk(8'(clk_cfg[0]), 8'h01);
    i_host.wr(12'h086, 8'hff);
    rchk(12'h086, 8'h00);
    rchk(12'h08d, 8'h1f);
    $display("driver and unmapped done");
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rchk(12'h084, 8'h00);
    rchk(12'h085, 8'h13);
    rchk(12'h08d, 8'h00);
    rchk(12'h08f, 8'h00);
    chk(8'(clk_cfg[1]), 8'h01);
    $display("mid-run reset done");
    summarize();
  end
endmodule

// ===== verif/scc_host.sv
module scc_host (
  input wire logic ref_clk,
  input wire logic [7:0] rdata,
  output logic [11:0] addr,
  output logic [7:0] wdata,
  output logic wr_stb,
  output logic rd_stb
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {addr, wdata, wr_stb, rd_stb} = '0;
  // One idle cycle between strobes keeps each edge single-driven
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    @(posedge ref_clk);
    d = rdata;
  endtask
endmodule

// ===== verif/scc_monitor.sv
module scc_monitor (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire scc_pkg::scc_ref_t ref_cfg,
  input wire scc_pkg::scc_seq_t seq_cfg,
  input wire scc_pkg::scc_clk_t clk_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_cpl;
    wr_stb && addr == 12'h084 |=> ref_cfg[1] == $past(wdata[6]);
  endproperty
  a_cpl: assert property (p_cpl) else $error("coupling");
  property p_rpd;
    wr_stb && addr == 12'h084 |=> ref_cfg[0] == $past(wdata[0]);
  endproperty
  a_rpd: assert property (p_rpd) else $error("receiver off");
  property p_swg;
    wr_stb && addr == 12'h08d |=> clk_cfg[7:3] == $past(wdata[4:0]);
  endproperty
  a_swg: assert property (p_swg) else $error("swing code");
  // Inversion follows the stored code, not the write
  property p_inv;
    clk_cfg[2] == (clk_cfg[7:3] inside {[5'h0a:5'h13]});
  endproperty
  a_inv: assert property (p_inv) else $error("inverted");
  property p_drv;
    wr_stb && addr == 12'h08f |=> clk_cfg[0] == $past(wdata[0]);
  endproperty
  a_drv: assert property (p_drv) else $error("driver off");
  property p_rsv;
    rd_stb && addr == 12'h08f |=> rdata[7:1] == 7'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
endmodule
bind scc_config_regs scc_monitor i_mon (.*);
